// ### design/fpbc_top.sv
// Functional notes
// R1 - zero boot status starts execution at address 0000
// R2 - nonzero boot status starts at boot vector high byte, low byte zero
// R3 - factory vector 0F or 1F, loader entry 0F00 or 1F00
// R4 - hardware loader force at power-on acts like nonzero boot status
// R5 - erase and program refused while flash brownout detector is tripped
// R6 - no read-back verify; 32-bit crc over one sector or whole space
// R7 - firmware loads registers then calls rom program entry at FF03
// R8 - control/status, data and two address registers drive programming
// R9 - factory loader occupies top 512 bytes of user code space
// R10 - user config bytes captured at power-up, frozen afterwards
// R11 - one security byte kept per 1 kB sector, four or eight
// R12 - serial loader host uses supply, ground, txd, rxd and reset
// R13 - programmer should zero boot status after programming
// R14 - software should page-erase loader sector, not sector-erase it
// R15 - 64-byte page buffer programs 1 to 64 bytes at once
// R16 - move-code reads from secured sectors are blocked
// R17 - busy until operation completes; brownout rejection flagged
`timescale 1ns/10ps
module fpbc_top #(
    parameter int SECTORS = 8,
    parameter int OP_CYCLES = fpbc_pkg::OP_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] boot_status_in,
    input wire logic [7:0] boot_vector_in,
    input wire logic vector_programmed_in,
    input wire logic force_loader_in,
    input wire logic [7:0] user_config_byte_a_in,
    input wire logic [7:0] user_config_byte_b_in,
    input wire logic [63:0] sector_security_in,
    input wire logic brownout_detector_in,
    input wire logic cmd_wr_in,
    input wire logic [3:0] cmd_in,
    input wire logic data_wr_in,
    input wire logic [7:0] data_in,
    input wire logic addr_hi_wr_in,
    input wire logic addr_lo_wr_in,
    input wire logic [7:0] addr_byte_in,
    input wire logic mc_req_in,
    input wire logic [15:0] mc_addr_in,
    input wire logic [7:0] flash_rdata_in,
    output logic [15:0] start_addr_out,
    output logic start_valid_out,
    output logic [7:0] cfg_a_out,
    output logic [7:0] cfg_b_out,
    output logic busy_out,
    output logic bod_reject_out,
    output logic op_done_out,
    output logic [31:0] crc_out,
    output logic [15:0] fl_addr_out,
    output logic [7:0] fl_wdata_out,
    output logic fl_prog_out,
    output logic fl_erase_out,
    output logic [1:0] fl_ekind_out,
    output logic fl_rd_out,
    output logic [7:0] mc_data_out,
    output logic mc_valid_out,
    output logic mc_blocked_out
);
    // ---------------------------------------------------------------
    // parameters and state
    // ---------------------------------------------------------------
    localparam int TMR_W = $clog2(OP_CYCLES + 1);
    // R9 loader entry
    localparam logic [7:0] FACTORY_VEC = fpbc_pkg::fpbc_factory_vector(SECTORS);
    localparam logic [15:0] LAST_ALL = 16'(SECTORS * fpbc_pkg::SECTOR_BYTES - 1);
    localparam logic [15:0] LAST_SEC = 16'(fpbc_pkg::SECTOR_BYTES - 1);
    localparam logic [5:0] LAST_PG = 6'(fpbc_pkg::PAGE_BYTES - 1);

    if (SECTORS != 4 && SECTORS != 8) begin : g_bad_sectors
        $error("fpbc_top: SECTORS must be 4 or 8");
    end
    if (OP_CYCLES < 1) begin : g_bad_cycles
        $error("fpbc_top: OP_CYCLES must be at least 1");
    end

    typedef struct packed {
        fpbc_pkg::fpbc_state_e st;
        logic started;
        logic [15:0] start_addr;
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        logic [7:0][7:0] sec;
        logic [15:0] addr;
        logic [7:0] data;
        logic [63:0][7:0] pbuf;
        logic [63:0] pvalid;
        logic [15:0] idx;
        logic [15:0] last;
        logic [TMR_W-1:0] tmr;
        logic bod_rej;
        logic done;
        logic [15:0] fl_addr;
        logic [7:0] fl_wdata;
        logic fl_prog;
        logic fl_erase;
        logic [1:0] fl_ekind;
        logic fl_rd;
        logic rd_mc;
        logic crc_clr;
        logic crc_en;
        logic [7:0] crc_byte;
        logic [7:0] mc_data;
        logic mc_valid;
        logic mc_blocked;
    } fpbc_top_s;

    fpbc_top_s r_ff;
    fpbc_top_s nxt_r;
    logic is_flash_op;
    logic [15:0] base;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        nxt_r.fl_prog = 1'b0;
        nxt_r.fl_erase = 1'b0;
        nxt_r.fl_rd = 1'b0;
        nxt_r.rd_mc = 1'b0;
        nxt_r.crc_clr = 1'b0;
        nxt_r.crc_en = 1'b0;
        nxt_r.mc_valid = 1'b0;
        nxt_r.mc_blocked = 1'b0;
        is_flash_op = cmd_in inside {fpbc_pkg::CMD_PROG, fpbc_pkg::CMD_ERASE_BYTE,
                                     fpbc_pkg::CMD_ERASE_PAGE, fpbc_pkg::CMD_ERASE_SECTOR};
        base = {r_ff.addr[15:fpbc_pkg::SECTOR_LSB], 10'h000};
        // R1 start vector
        // R2 start vector
        // R4 forced loader entry
        // R10 config capture
        // R11 security capture
        if (!r_ff.started) begin
            nxt_r.started = 1'b1;
            nxt_r.cfg_a = user_config_byte_a_in;
            nxt_r.cfg_b = user_config_byte_b_in;
            nxt_r.sec = sector_security_in;
            if (boot_status_in != 8'h00 || force_loader_in) begin
                // R3 factory vector
                nxt_r.start_addr = {vector_programmed_in ? boot_vector_in : FACTORY_VEC, fpbc_pkg::START_LOW};
            end else begin
                nxt_r.start_addr = fpbc_pkg::APP_START;
            end
        end
        // R8 address registers
        if (addr_hi_wr_in) begin
            nxt_r.addr[15:8] = addr_byte_in;
        end
        if (addr_lo_wr_in) begin
            nxt_r.addr[7:0] = addr_byte_in;
        end
        if (data_wr_in) begin
            nxt_r.data = data_in;
        end
        // flash read data is sampled in the same cycle that the read strobe is out
        if (r_ff.fl_rd && r_ff.rd_mc) begin
            nxt_r.mc_data = flash_rdata_in;
            nxt_r.mc_valid = 1'b1;
        end else if (r_ff.fl_rd) begin
            nxt_r.crc_en = 1'b1;
            nxt_r.crc_byte = flash_rdata_in;
        end
        case (r_ff.st)
            fpbc_pkg::FPBC_IDLE: begin
                if (cmd_wr_in && r_ff.started) begin
                    // R5 brownout lockout
                    // R17 reject flag
                    if (is_flash_op && brownout_detector_in) begin
                        nxt_r.bod_rej = 1'b1;
                    end else begin
                        nxt_r.bod_rej = 1'b0;
                        nxt_r.idx = 16'h0000;
                        nxt_r.fl_ekind = fpbc_pkg::EKIND_BYTE;
                        case (cmd_in)
                            // R15 page buffer load
                            fpbc_pkg::CMD_LOAD: begin
                                nxt_r.pbuf[r_ff.addr[5:0]] = r_ff.data;
                                nxt_r.pvalid[r_ff.addr[5:0]] = 1'b1;
                            end
                            fpbc_pkg::CMD_PROG: nxt_r.st = fpbc_pkg::FPBC_PROG;
                            fpbc_pkg::CMD_ERASE_BYTE: nxt_r.st = fpbc_pkg::FPBC_ERASE;
                            fpbc_pkg::CMD_ERASE_PAGE: begin
                                nxt_r.st = fpbc_pkg::FPBC_ERASE;
                                nxt_r.fl_ekind = fpbc_pkg::EKIND_PAGE;
                            end
                            fpbc_pkg::CMD_ERASE_SECTOR: begin
                                nxt_r.st = fpbc_pkg::FPBC_ERASE;
                                nxt_r.fl_ekind = fpbc_pkg::EKIND_SECTOR;
                            end
                            // R6 crc instead of read-back
                            fpbc_pkg::CMD_CRC_SECTOR, fpbc_pkg::CMD_CRC_ALL: begin
                                nxt_r.st = fpbc_pkg::FPBC_CRC;
                                nxt_r.crc_clr = 1'b1;
                                nxt_r.last = (cmd_in == fpbc_pkg::CMD_CRC_ALL) ? LAST_ALL : LAST_SEC;
                                if (cmd_in == fpbc_pkg::CMD_CRC_ALL) begin
                                    nxt_r.addr = fpbc_pkg::APP_START;
                                end
                            end
                            default: nxt_r.bod_rej = r_ff.bod_rej;
                        endcase
                    end
                end else if (mc_req_in) begin
                    // R16 secured sector read block
                    if (!r_ff.started || r_ff.sec[fpbc_pkg::fpbc_sector_of(mc_addr_in)][fpbc_pkg::SECURE_BIT]) begin
                        nxt_r.mc_valid = 1'b1;
                        nxt_r.mc_blocked = 1'b1;
                        nxt_r.mc_data = 8'h00;
                    end else begin
                        nxt_r.fl_rd = 1'b1;
                        nxt_r.rd_mc = 1'b1;
                        nxt_r.fl_addr = mc_addr_in;
                    end
                end
            end
            // R15 page program walk
            fpbc_pkg::FPBC_PROG: begin
                nxt_r.fl_prog = r_ff.pvalid[r_ff.idx[5:0]];
                nxt_r.fl_addr = {r_ff.addr[15:fpbc_pkg::PAGE_LSB], r_ff.idx[5:0]};
                nxt_r.fl_wdata = r_ff.pbuf[r_ff.idx[5:0]];
                nxt_r.idx = r_ff.idx + 16'h0001;
                if (r_ff.idx[5:0] == LAST_PG) begin
                    nxt_r.pvalid = '0;
                    nxt_r.st = fpbc_pkg::FPBC_WAIT;
                    nxt_r.tmr = TMR_W'(OP_CYCLES);
                end
            end
            fpbc_pkg::FPBC_ERASE: begin
                nxt_r.fl_erase = 1'b1;
                nxt_r.fl_addr = r_ff.addr;
                nxt_r.st = fpbc_pkg::FPBC_WAIT;
                nxt_r.tmr = TMR_W'(OP_CYCLES);
            end
            // R6 crc read walk
            fpbc_pkg::FPBC_CRC: begin
                nxt_r.fl_rd = 1'b1;
                nxt_r.fl_addr = base + r_ff.idx;
                nxt_r.idx = r_ff.idx + 16'h0001;
                if (r_ff.idx == r_ff.last) begin
                    nxt_r.st = fpbc_pkg::FPBC_WAIT;
                    nxt_r.tmr = TMR_W'(fpbc_pkg::CRC_TAIL);
                end
            end
            // R17 busy until done
            fpbc_pkg::FPBC_WAIT: begin
                nxt_r.tmr = r_ff.tmr - TMR_W'(1);
                if (r_ff.tmr == TMR_W'(1)) begin
                    nxt_r.st = fpbc_pkg::FPBC_IDLE;
                    nxt_r.done = 1'b1;
                end
            end
            default: nxt_r.st = fpbc_pkg::FPBC_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // state register and crc engine
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    fpbc_crc32 u_crc (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(r_ff.crc_clr),
        .en_in(r_ff.crc_en),
        .byte_in(r_ff.crc_byte),
        .crc_out(crc_out)
    );

    assign start_addr_out = r_ff.start_addr;
    assign start_valid_out = r_ff.started;
    assign cfg_a_out = r_ff.cfg_a;
    assign cfg_b_out = r_ff.cfg_b;
    assign busy_out = (r_ff.st != fpbc_pkg::FPBC_IDLE);
    assign bod_reject_out = r_ff.bod_rej;
    assign op_done_out = r_ff.done;
    assign fl_addr_out = r_ff.fl_addr;
    assign fl_wdata_out = r_ff.fl_wdata;
    assign fl_prog_out = r_ff.fl_prog;
    assign fl_erase_out = r_ff.fl_erase;
    assign fl_ekind_out = r_ff.fl_ekind;
    assign fl_rd_out = r_ff.fl_rd;
    assign mc_data_out = r_ff.mc_data;
    assign mc_valid_out = r_ff.mc_valid;
    assign mc_blocked_out = r_ff.mc_blocked;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_app_start;
        $rose(start_valid_out) && $past(boot_status_in) == 8'h00 && !$past(force_loader_in)
            |-> start_addr_out == fpbc_pkg::APP_START;
    endproperty
    a_app_start: assert property (p_app_start) else $error("zero boot status did not start at 0000"); // R1
    property p_vec_start;
        $rose(start_valid_out) && $past(boot_status_in) != 8'h00 && $past(vector_programmed_in)
            |-> start_addr_out == {$past(boot_vector_in), fpbc_pkg::START_LOW};
    endproperty
    a_vec_start: assert property (p_vec_start) else $error("boot vector start address wrong"); // R2
    property p_factory;
        $rose(start_valid_out) && ($past(boot_status_in) != 8'h00 || $past(force_loader_in))
            && !$past(vector_programmed_in)
            |-> start_addr_out == {FACTORY_VEC, fpbc_pkg::START_LOW};
    endproperty
    a_factory: assert property (p_factory) else $error("factory loader entry wrong"); // R3
    property p_force;
        $rose(start_valid_out) && $past(force_loader_in) |-> start_addr_out != fpbc_pkg::APP_START;
    endproperty
    a_force: assert property (p_force) else $error("forced loader ignored"); // R4
    property p_bod;
        cmd_wr_in && is_flash_op && brownout_detector_in && !busy_out && start_valid_out
            |=> bod_reject_out && !busy_out ##1 !fl_erase_out && !fl_prog_out;
    endproperty
    a_bod: assert property (p_bod) else $error("flash operation ran during brownout"); // R5
    // sector crc cycle count; its span is beyond a delay range
    logic [10:0] crc_cyc_ff;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            crc_cyc_ff <= 11'h000;
        end else if (cmd_wr_in && cmd_in == fpbc_pkg::CMD_CRC_SECTOR && !busy_out && start_valid_out) begin
            crc_cyc_ff <= 11'h001;
        end else if (op_done_out) begin
            crc_cyc_ff <= 11'h000;
        end else if (crc_cyc_ff != 11'h000) begin
            crc_cyc_ff <= crc_cyc_ff + 11'h001;
        end
    end
    property p_crc_sector;
        crc_cyc_ff != 11'h000 |-> (op_done_out ? (crc_cyc_ff >= 11'h400 && crc_cyc_ff <= 11'h408) : busy_out);
    endproperty
    a_crc_sector: assert property (p_crc_sector) else $error("sector crc length wrong"); // R6
    property p_cfg_frozen;
        start_valid_out && $past(start_valid_out) |-> $stable(cfg_a_out) && $stable(cfg_b_out);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("config bytes changed after start"); // R10
    property p_page;
        fl_prog_out |-> fl_addr_out[15:6] == r_ff.addr[15:6] && $past(busy_out);
    endproperty
    a_page: assert property (p_page) else $error("program outside addressed page"); // R15
    property p_secure;
        mc_req_in && !cmd_wr_in && !busy_out && start_valid_out
            && r_ff.sec[fpbc_pkg::fpbc_sector_of(mc_addr_in)][fpbc_pkg::SECURE_BIT]
            |=> mc_valid_out && mc_blocked_out && mc_data_out == 8'h00 && !fl_rd_out;
    endproperty
    a_secure: assert property (p_secure) else $error("secured sector read leaked"); // R16
    property p_busy;
        cmd_wr_in && cmd_in == fpbc_pkg::CMD_ERASE_PAGE && !brownout_detector_in && !busy_out
            && start_valid_out |=> busy_out [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped during erase"); // R17

    c_erase: cover property (fl_erase_out ##[1:1000] busy_out);
    c_prog: cover property (fl_prog_out);
    c_crc_done: cover property (busy_out ##1 op_done_out);
    c_blocked: cover property (mc_blocked_out);
endmodule : fpbc_top

// ### design/fpbc_pkg.sv
package fpbc_pkg;
    // ---------------------------------------------------------------
    // memory geometry
    // ---------------------------------------------------------------
    localparam int SECTOR_BYTES = 1024;
    localparam int PAGE_BYTES = 64;
    localparam int LOADER_BYTES = 512;
    localparam int ADDR_W = 16;
    localparam int SECTOR_LSB = 10;
    localparam int PAGE_LSB = 6;
    localparam int SECURE_BIT = 0;

    // start address forming
    localparam logic [15:0] APP_START = 16'h0000;
    localparam logic [7:0] START_LOW = 8'h00;

    // command codes written to the control register
    localparam logic [3:0] CMD_LOAD = 4'h1;
    localparam logic [3:0] CMD_PROG = 4'h2;
    localparam logic [3:0] CMD_ERASE_BYTE = 4'h3;
    localparam logic [3:0] CMD_ERASE_PAGE = 4'h4;
    localparam logic [3:0] CMD_ERASE_SECTOR = 4'h5;
    localparam logic [3:0] CMD_CRC_SECTOR = 4'h6;
    localparam logic [3:0] CMD_CRC_ALL = 4'h7;

    // erase kind driven to the flash macro
    localparam logic [1:0] EKIND_BYTE = 2'h0;
    localparam logic [1:0] EKIND_PAGE = 2'h1;
    localparam logic [1:0] EKIND_SECTOR = 2'h2;

    // crc
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;

    // timing
    localparam int OP_TIME_US = 2000;
    localparam int CLK_MHZ = 125;
    localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
    localparam int CRC_TAIL = 3;

    // ---------------------------------------------------------------
    // types and helpers
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        FPBC_IDLE = 3'h0,
        FPBC_PROG = 3'h1,
        FPBC_ERASE = 3'h3,
        FPBC_WAIT = 3'h2,
        FPBC_CRC = 3'h6
    } fpbc_state_e;

    function automatic logic [2:0] fpbc_sector_of(input logic [15:0] addr);
        fpbc_sector_of = addr[SECTOR_LSB+2:SECTOR_LSB];
    endfunction : fpbc_sector_of

    // loader entry sits in the middle of the top loader area
    function automatic logic [7:0] fpbc_factory_vector(input int sectors);
        fpbc_factory_vector = 8'((sectors * SECTOR_BYTES - LOADER_BYTES / 2) >> 8);
    endfunction : fpbc_factory_vector
endpackage : fpbc_pkg

// ### design/fpbc_crc32.sv
`timescale 1ns/10ps
module fpbc_crc32 (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clear_in,
    input wire logic en_in,
    input wire logic [7:0] byte_in,
    output logic [31:0] crc_out
);
    typedef struct packed {
        logic [31:0] crc;
    } fpbc_crc_s;

    fpbc_crc_s r_ff;
    fpbc_crc_s nxt_r;

    // reflected crc-32, one byte per clock, no final inversion
    function automatic logic [31:0] fpbc_crc_step(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] v;
        v = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            v = v[0] ? ((v >> 1) ^ fpbc_pkg::CRC_POLY) : (v >> 1);
        end
        fpbc_crc_step = v;
    endfunction : fpbc_crc_step

    // clear has priority so a new run never folds in a stale byte
    always_comb begin
        nxt_r = r_ff;
        if (clear_in) begin
            nxt_r.crc = fpbc_pkg::CRC_INIT;
        end else if (en_in) begin
            nxt_r.crc = fpbc_crc_step(r_ff.crc, byte_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r_ff <= '{crc: fpbc_pkg::CRC_INIT};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign crc_out = r_ff.crc;
endmodule : fpbc_crc32

// ### sim/fpbc_flash_model.sv
`timescale 1ns/10ps
module fpbc_flash_model (
    input wire logic clk_in,
    input wire logic fl_rd_in,
    input wire logic [15:0] fl_addr_in,
    output logic [7:0] rdata_out
);
    logic [15:0] last_addr_ff = 16'h0000;

    // contents are a pattern of the address
    function automatic logic [7:0] fpbc_cell(input logic [15:0] a);
        return a[7:0] ^ {5'h0A, a[12:10]};
    endfunction : fpbc_cell

    // remember the last address read
    always_ff @(posedge clk_in) begin
        if (fl_rd_in) begin
            last_addr_ff <= fl_addr_in;
        end
    end

    // outside a read the line shows the inverse, so a late sample is caught
    always_comb begin
        if (fl_rd_in) begin
            rdata_out = fpbc_cell(fl_addr_in);
        end else begin
            rdata_out = ~fpbc_cell(last_addr_ff);
        end
    end
endmodule : fpbc_flash_model

// ### sim/flash_program_boot_control_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
end

module flash_program_boot_control_tb;
    // short program/erase time keeps the run brief
    localparam int OPC = 8;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] boot_status_in = 8'h00, boot_vector_in = 8'h3A, cfg_a = 8'h00, cfg_b = 8'h00;
    logic vector_programmed_in = 1'b1, force_loader_in = 1'b0, brownout_detector_in = 1'b0;
    logic [63:0] sector_security_in = 64'h0100_0000_0001_0000;
    logic cmd_wr_in = 1'b0, data_wr_in = 1'b0, addr_hi_wr_in = 1'b0, addr_lo_wr_in = 1'b0, mc_req_in = 1'b0;
    logic [3:0] cmd_in = 4'h0;
    logic [7:0] data_in = 8'h00, addr_byte_in = 8'h00, flash_rdata_in;
    logic [15:0] mc_addr_in = 16'h0000;
    logic [15:0] start_addr_out, fl_addr_out;
    logic [7:0] cfg_a_out, cfg_b_out, fl_wdata_out, mc_data_out;
    logic start_valid_out, busy_out, bod_reject_out, op_done_out, fl_prog_out, fl_erase_out;
    logic fl_rd_out, mc_valid_out, mc_blocked_out;
    logic [1:0] fl_ekind_out;
    logic [31:0] crc_out;
    int errors = 0, check_count = 0, cycles = 0, erase_n = 0;
    logic [23:0] prog_q [$];

    fpbc_top #(.SECTORS(8), .OP_CYCLES(OPC)) i_fpbc_top (.*, .user_config_byte_a_in(cfg_a),
        .user_config_byte_b_in(cfg_b));

    fpbc_flash_model i_fpbc_flash_model (.clk_in(clk_in), .fl_rd_in(fl_rd_out), .fl_addr_in(fl_addr_out),
        .rdata_out(flash_rdata_in));

    always #4 clk_in = ~clk_in;

    // -----------------------------------------------------------
    // monitors, timeout and verdict
    // -----------------------------------------------------------
    // sampled mid-cycle
    always @(negedge clk_in) begin
        if (fl_prog_out === 1'b1) prog_q.push_back({fl_addr_out, fl_wdata_out});
        if (fl_erase_out === 1'b1) erase_n++;
    end

    // ceiling above the whole-space crc
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // -----------------------------------------------------------
    // drivers
    // -----------------------------------------------------------
    task automatic do_reset(input logic [7:0] st, input logic vp, input logic fc, input logic [7:0] cf);
        @(posedge clk_in) #1 rst_b_in = 1'b0;
        boot_status_in = st;
        vector_programmed_in = vp;
        force_loader_in = fc;
        cfg_a = cf;
        cfg_b = ~cf;
        repeat (8) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : do_reset

    task automatic cmd(input logic [3:0] c);
        @(posedge clk_in) #1 cmd_wr_in = 1'b1;
        cmd_in = c;
        @(posedge clk_in) #1 cmd_wr_in = 1'b0;
    endtask : cmd

    task automatic set_addr(input logic [15:0] a);
        @(posedge clk_in) #1 addr_hi_wr_in = 1'b1;
        addr_byte_in = a[15:8];
        @(posedge clk_in) #1 addr_hi_wr_in = 1'b0;
        addr_lo_wr_in = 1'b1;
        addr_byte_in = a[7:0];
        @(posedge clk_in) #1 addr_lo_wr_in = 1'b0;
    endtask : set_addr

    task automatic load(input logic [15:0] a, input logic [7:0] d);
        set_addr(a);
        data_wr_in = 1'b1;
        data_in = d;
        @(posedge clk_in) #1 data_wr_in = 1'b0;
        cmd(fpbc_pkg::CMD_LOAD);
    endtask : load

    task automatic wait_done(input int bound, output int n);
        n = 0;
        while (op_done_out !== 1'b1 && n < bound) begin
            @(posedge clk_in) #1 n++;
        end
        `CHK("op_done", 1'b1, op_done_out)
        `CHK("busy_at_done", 1'b0, busy_out)
    endtask : wait_done

    function automatic logic [31:0] crc_exp(input int base, input int len);
        logic [31:0] c;
        logic [15:0] a;
        c = fpbc_pkg::CRC_INIT;
        for (int i = 0; i < len; i++) begin
            a = 16'(base + i);
            c = c ^ {24'h0, a[7:0] ^ {5'h0A, a[12:10]}};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ fpbc_pkg::CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_exp

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_boot();
        logic [7:0] st [4] = '{8'h5A, 8'h01, 8'h00, 8'h00};
        logic vp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic fc [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        logic [15:0] ex [4] = '{16'h3A00, 16'h1F00, 16'h3A00, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            do_reset(st[i], vp[i], fc[i], 8'hC0 + 8'(i));
            `CHK("start_addr", ex[i], start_addr_out)
            `CHK("start_valid", 1'b1, start_valid_out)
            {cfg_a, cfg_b} = 16'h0000;
            repeat (2) @(posedge clk_in);
            #1;
            `CHK("cfg_a", 8'hC0 + 8'(i), cfg_a_out)
            `CHK("cfg_b", ~(8'hC0 + 8'(i)), cfg_b_out)
        end
    endtask : t_boot

    task automatic t_brownout();
        brownout_detector_in = 1'b1;
        set_addr(16'h1C40);
        cmd(fpbc_pkg::CMD_ERASE_PAGE);
        `CHK("bod_reject", 1'b1, bod_reject_out)
        `CHK("bod_busy", 1'b0, busy_out)
        cmd(fpbc_pkg::CMD_PROG);
        repeat (OPC + 4) @(posedge clk_in);
        #1;
        `CHK("bod_erase_n", 0, erase_n)
        `CHK("bod_prog_n", 0, prog_q.size())
        brownout_detector_in = 1'b0;
    endtask : t_brownout

    task automatic t_erase();
        logic [3:0] cm [3] = '{fpbc_pkg::CMD_ERASE_BYTE, fpbc_pkg::CMD_ERASE_PAGE, fpbc_pkg::CMD_ERASE_SECTOR};
        logic [1:0] ek [3] = '{fpbc_pkg::EKIND_BYTE, fpbc_pkg::EKIND_PAGE, fpbc_pkg::EKIND_SECTOR};
        logic [15:0] ad [3] = '{16'h1C05, 16'h1C40, 16'h0400};
        int n;
        for (int i = 0; i < 3; i++) begin
            set_addr(ad[i]);
            cmd(cm[i]);
            `CHK("busy", 1'b1, busy_out)
            `CHK("bod_cleared", 1'b0, bod_reject_out)
            @(posedge clk_in) #1;
            `CHK("erase_pulse", 1'b1, fl_erase_out)
            `CHK("erase_kind", ek[i], fl_ekind_out)
            `CHK("erase_addr", ad[i], fl_addr_out)
            cmd(fpbc_pkg::CMD_ERASE_SECTOR);
            wait_done(100, n);
            `CHK("erase_time", 1'b1, (n + 2 >= OPC) && (n + 2 <= OPC + 1))
        end
        `CHK("erase_count", 3, erase_n)
    endtask : t_erase

    task automatic t_prog();
        int n;
        load(16'h0805, 8'h11);
        load(16'h083F, 8'h22);
        set_addr(16'h0800);
        cmd(fpbc_pkg::CMD_PROG);
        wait_done(200, n);
        `CHK("prog_n", 2, prog_q.size())
        `CHK("prog_0", 24'h080511, prog_q[0])
        `CHK("prog_1", 24'h083F22, prog_q[1])
        // buffer empties after program
        cmd(fpbc_pkg::CMD_PROG);
        wait_done(200, n);
        `CHK("prog_empty", 2, prog_q.size())
    endtask : t_prog

    task automatic mc_read(input logic [15:0] a, input logic blk);
        int n;
        @(posedge clk_in) #1 mc_req_in = 1'b1;
        mc_addr_in = a;
        @(posedge clk_in) #1 mc_req_in = 1'b0;
        n = 0;
        while (mc_valid_out !== 1'b1 && n < 4) begin
            @(posedge clk_in) #1 n++;
        end
        `CHK("mc_valid", 1'b1, mc_valid_out)
        `CHK("mc_blocked", blk, mc_blocked_out)
        `CHK("mc_data", blk ? 8'h00 : (a[7:0] ^ {5'h0A, a[12:10]}), mc_data_out)
    endtask : mc_read

    task automatic t_crc();
        int n;
        set_addr(16'h0C00);
        cmd(fpbc_pkg::CMD_CRC_SECTOR);
        `CHK("crc_busy", 1'b1, busy_out)
        wait_done(3000, n);
        `CHK("crc_sector", crc_exp(16'h0C00, 1024), crc_out)
        set_addr(16'h1234);
        cmd(fpbc_pkg::CMD_CRC_ALL);
        wait_done(12000, n);
        `CHK("crc_all", crc_exp(0, 8192), crc_out)
    endtask : t_crc

    initial begin
        t_boot();
        t_brownout();
        t_erase();
        t_prog();
        mc_read(16'h0810, 1'b1);
        mc_read(16'h1FFF, 1'b1);
        mc_read(16'h0405, 1'b0);
        t_crc();
        tally_and_finish();
    end
endmodule : flash_program_boot_control_tb
